/* logic/ptr_pkg.sv */
// shared constants and types for the pulse train position reference block
package ptr_pkg;
  localparam int CLK_MHZ = 100;

  // register byte offsets
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_ACTIVE = 8'h04;
  localparam logic [7:0] ADDR_CONTROL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_POSITION = 8'h10;
  localparam logic [7:0] ADDR_FWD_COUNT = 8'h14;
  localparam logic [7:0] ADDR_REV_COUNT = 8'h18;

  // field positions in config and active registers
  localparam int CFG_METHOD_LSB = 0;
  localparam int CFG_FORM_LSB = 4;
  localparam int CFG_FILTER_LSB = 8;
  // pending config matches the active reset values: method 1, form 0, filter 0
  localparam logic [31:0] CFG_RESET = 32'h0000_0001;
  localparam logic [3:0] METHOD_PULSE = 4'h1;
  localparam logic [3:0] METHOD_RESET = 4'h1;

  // control and status bit positions
  localparam int CTRL_RESTART_BIT = 0;
  localparam int CTRL_CLEAR_BIT = 1;
  localparam int STAT_MODE_BIT = 0;
  localparam int STAT_PENDING_BIT = 1;
  localparam int STAT_CFG_ERR_BIT = 2;
  localparam int STAT_LINE_A_BIT = 3;
  localparam int STAT_LINE_B_BIT = 4;

  typedef enum logic [2:0] {
    PTR_SIGN_POS = 3'b000,
    PTR_DUAL_POS = 3'b001,
    PTR_QUAD_X1 = 3'b010,
    PTR_QUAD_X2 = 3'b011,
    PTR_QUAD_X4 = 3'b100,
    PTR_SIGN_NEG = 3'b101,
    PTR_DUAL_NEG = 3'b110
  } ptr_form_t;

  typedef enum logic [1:0] {
    PTR_FILT_LINE = 2'b00,
    PTR_FILT_OPEN = 2'b01,
    PTR_FILT_LINE2 = 2'b10
  } ptr_filter_t;

  localparam ptr_form_t FORM_RESET = PTR_SIGN_POS;
  localparam ptr_filter_t FILTER_RESET = PTR_FILT_LINE;

  // least accepted pulse width per filter; rounded up to whole cycles
  localparam int FILT_LINE_NS = 250;
  localparam int FILT_OPEN_NS = 1000;
  localparam int FILT_LINE2_NS = 50;
  localparam logic [7:0] FILT_LINE_CYC = 8'((FILT_LINE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FILT_OPEN_CYC = 8'((FILT_OPEN_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] FILT_LINE2_CYC = 8'((FILT_LINE2_NS * CLK_MHZ + 999) / 1000);
endpackage

/* logic/ptr_in_filter.sv */
// two-line synchroniser and pulse width filter
module ptr_in_filter import ptr_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [1:0] line_raw,
  input wire logic [7:0] min_width,
  output logic [1:0] line_clean
);
  typedef struct packed {
    logic [1:0] sync1;
    logic [1:0] sync2;
    logic [1:0] clean;
    logic [1:0][7:0] width_cnt;
  } ptr_filt_state_t;

  ptr_filt_state_t st;
  ptr_filt_state_t next_st;

  always_comb begin
    next_st = st;
    next_st.sync1 = line_raw;
    next_st.sync2 = st.sync1;
    for (int i = 0; i < 2; i++) begin
      // only the second stage is looked at; the first may be metastable
      if (st.sync2[i] == st.clean[i]) begin
        next_st.width_cnt[i] = 8'h00;
      end else if (st.width_cnt[i] + 8'h01 >= min_width) begin
        next_st.clean[i] = st.sync2[i];
        next_st.width_cnt[i] = 8'h00;
      end else begin
        next_st.width_cnt[i] = st.width_cnt[i] + 8'h01;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign line_clean = st.clean;
endmodule

/* logic/ptr_decoder.sv */
// turns filtered reference lines into forward and reverse steps
module ptr_decoder import ptr_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic resync,
  input wire ptr_form_t form,
  input wire logic line_a,
  input wire logic line_b,
  output logic fwd_step,
  output logic rev_step
);
  typedef struct packed {
    logic prev_a;
    logic prev_b;
    logic fwd;
    logic rev;
  } ptr_dec_state_t;

  ptr_dec_state_t st;
  ptr_dec_state_t next_st;
  logic neg;
  logic a;
  logic b;
  logic chg_a;
  logic chg_b;
  logic quad_fwd;

  always_comb begin
    neg = (form == PTR_SIGN_NEG) || (form == PTR_DUAL_NEG);
    a = line_a ^ neg;
    b = line_b ^ neg;
    chg_a = a ^ st.prev_a;
    chg_b = b ^ st.prev_b;
    // b leading a gives 00-01-11-10, for which prev_a differs from new b
    quad_fwd = st.prev_a ^ b;
    next_st = st;
    next_st.prev_a = a;
    next_st.prev_b = b;
    next_st.fwd = 1'b0;
    next_st.rev = 1'b0;
    unique case (form)
      PTR_SIGN_POS, PTR_SIGN_NEG: begin
        next_st.fwd = a && !st.prev_a && b;
        next_st.rev = a && !st.prev_a && !b;
      end
      PTR_DUAL_POS, PTR_DUAL_NEG: begin
        next_st.fwd = a && !st.prev_a;
        next_st.rev = b && !st.prev_b;
      end
      PTR_QUAD_X1: begin
        next_st.fwd = chg_a && !chg_b && a && quad_fwd;
        next_st.rev = chg_a && !chg_b && a && !quad_fwd;
      end
      PTR_QUAD_X2: begin
        next_st.fwd = chg_a && !chg_b && quad_fwd;
        next_st.rev = chg_a && !chg_b && !quad_fwd;
      end
      PTR_QUAD_X4: begin
        next_st.fwd = (chg_a ^ chg_b) && quad_fwd;
        next_st.rev = (chg_a ^ chg_b) && !quad_fwd;
      end
      default: begin
        next_st.fwd = 1'b0;
        next_st.rev = 1'b0;
      end
    endcase
    // a resync only takes the line levels, so a mode change makes no step
    if (!enable || resync) begin
      next_st.fwd = 1'b0;
      next_st.rev = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fwd_step = st.fwd;
  assign rev_step = st.rev;
endmodule

/* logic/ptr_pulse_ref.sv */
// pulse train position reference decoder with apb register access
// Operation
// - pulse mode at method code 1, after restart
// - seven pulse form codes decoded
// - sign plus pulse: step counts, sign gives direction
// - dual pulse: forward line up, reverse down
// - quadrature: b leading a is forward
// - quadrature codes multiply by one, two, four
// - filter code 0: line driver, 1 Mpps
// - filter code 1: open collector, 200 kpps
// - filter code 2: line driver, 4 Mpps
// - conducting open collector reads as high
module ptr_pulse_ref import ptr_pkg::*; (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ref_in_a,
  input wire logic ref_in_b,
  output logic [31:0] pos_total,
  output logic pos_fwd_step,
  output logic pos_rev_step,
  output logic position_mode
);
  typedef struct packed {
    logic [31:0] cfg_pending;
    logic [3:0] method;
    ptr_form_t form;
    ptr_filter_t filter;
    logic resync;
    logic cfg_error;
    logic [31:0] total;
    logic [31:0] fwd_count;
    logic [31:0] rev_count;
    logic fwd_out;
    logic rev_out;
    logic pos_mode;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } ptr_state_t;

  ptr_state_t st;
  ptr_state_t next_st;
  logic [1:0] lines_clean;
  logic dec_fwd;
  logic dec_rev;
  logic [7:0] filt_width;
  logic acc_start;
  logic acc_write;
  logic [3:0] new_method;
  logic [3:0] new_form;
  logic [3:0] new_filter;
  logic [31:0] active_word;
  logic [31:0] status_word;

  function automatic logic [7:0] filter_cycles(input ptr_filter_t f);
    logic [7:0] cyc;
    cyc = FILT_LINE_CYC;
    unique case (f)
      PTR_FILT_LINE: cyc = FILT_LINE_CYC;
      PTR_FILT_OPEN: cyc = FILT_OPEN_CYC;
      PTR_FILT_LINE2: cyc = FILT_LINE2_CYC;
      default: cyc = FILT_LINE_CYC;
    endcase
    return cyc;
  endfunction

  function automatic logic addr_known(input logic [7:0] a);
    return (a == ADDR_CONFIG) || (a == ADDR_ACTIVE) || (a == ADDR_CONTROL) ||
           (a == ADDR_STATUS) || (a == ADDR_POSITION) || (a == ADDR_FWD_COUNT) ||
           (a == ADDR_REV_COUNT);
  endfunction

  // an open-collector source pulls the line high when conducting, so the
  // pin level is used as is and no inversion sits here
  ptr_in_filter u_filter (
    .ref_clk(ref_clk),
    .reset(reset),
    .line_raw({ref_in_b, ref_in_a}),
    .min_width(filt_width),
    .line_clean(lines_clean)
  );

  // ref_in_a serves as step, forward_pulse_line or phase a;
  // ref_in_b as sign, reverse_pulse_line or phase b
  ptr_decoder u_decoder (
    .ref_clk(ref_clk),
    .reset(reset),
    .enable(st.pos_mode),
    .resync(st.resync),
    .form(st.form),
    .line_a(lines_clean[0]),
    .line_b(lines_clean[1]),
    .fwd_step(dec_fwd),
    .rev_step(dec_rev)
  );

  always_comb begin
    filt_width = filter_cycles(st.filter);
    acc_start = psel && penable && !st.pready;
    acc_write = psel && penable && st.pready && pwrite && addr_known(paddr);
    new_method = st.cfg_pending[CFG_METHOD_LSB +: 4];
    new_form = st.cfg_pending[CFG_FORM_LSB +: 4];
    new_filter = st.cfg_pending[CFG_FILTER_LSB +: 4];

    active_word = 32'h0000_0000;
    active_word[CFG_METHOD_LSB +: 4] = st.method;
    active_word[CFG_FORM_LSB +: 4] = {1'b0, st.form};
    active_word[CFG_FILTER_LSB +: 4] = {2'b00, st.filter};

    status_word = 32'h0000_0000;
    status_word[STAT_MODE_BIT] = st.pos_mode;
    status_word[STAT_PENDING_BIT] = (st.cfg_pending != active_word);
    status_word[STAT_CFG_ERR_BIT] = st.cfg_error;
    status_word[STAT_LINE_A_BIT] = lines_clean[0];
    status_word[STAT_LINE_B_BIT] = lines_clean[1];

    next_st = st;
    next_st.resync = 1'b0;
    next_st.fwd_out = dec_fwd;
    next_st.rev_out = dec_rev;
    next_st.pos_mode = (st.method == METHOD_PULSE);

    // one wait state: pready rises in the second access cycle
    next_st.pready = acc_start;
    next_st.pslverr = acc_start && !addr_known(paddr);
    if (acc_start && !pwrite) begin
      unique case (paddr)
        ADDR_CONFIG: next_st.prdata = st.cfg_pending;
        ADDR_ACTIVE: next_st.prdata = active_word;
        ADDR_STATUS: next_st.prdata = status_word;
        ADDR_POSITION: next_st.prdata = st.total;
        ADDR_FWD_COUNT: next_st.prdata = st.fwd_count;
        ADDR_REV_COUNT: next_st.prdata = st.rev_count;
        default: next_st.prdata = 32'h0000_0000;
      endcase
    end else if (acc_start) begin
      next_st.prdata = 32'h0000_0000;
    end

    // running totals; each cycle carries at most one step of each kind
    if (dec_fwd && !dec_rev) begin
      next_st.total = st.total + 32'h0000_0001;
    end else if (dec_rev && !dec_fwd) begin
      next_st.total = st.total - 32'h0000_0001;
    end
    if (dec_fwd) begin
      next_st.fwd_count = st.fwd_count + 32'h0000_0001;
    end
    if (dec_rev) begin
      next_st.rev_count = st.rev_count + 32'h0000_0001;
    end

    if (acc_write) begin
      unique case (paddr)
        ADDR_CONFIG: begin
          // stored only; nothing changes in the datapath until restart
          next_st.cfg_pending = pwdata;
        end
        ADDR_CONTROL: begin
          if (pwdata[CTRL_RESTART_BIT]) begin
            next_st.method = new_method;
            if (new_form <= 4'h6) begin
              next_st.form = ptr_form_t'(new_form[2:0]);
            end
            if (new_filter <= 4'h2) begin
              next_st.filter = ptr_filter_t'(new_filter[1:0]);
            end
            next_st.resync = 1'b1;
          end
          if (pwdata[CTRL_RESTART_BIT] || pwdata[CTRL_CLEAR_BIT]) begin
            next_st.total = 32'h0000_0000;
            next_st.fwd_count = 32'h0000_0000;
            next_st.rev_count = 32'h0000_0000;
          end
        end
        ADDR_STATUS: begin
          if (pwdata[STAT_CFG_ERR_BIT]) begin
            next_st.cfg_error = 1'b0;
          end
        end
        default: begin
          next_st.cfg_pending = st.cfg_pending;
        end
      endcase
    end

    // a bad code at restart is flagged; the set wins over a clear
    if (acc_write && (paddr == ADDR_CONTROL) && pwdata[CTRL_RESTART_BIT] &&
        ((new_form > 4'h6) || (new_filter > 4'h2))) begin
      next_st.cfg_error = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st <= '0;
      st.cfg_pending <= CFG_RESET;
      st.method <= METHOD_RESET;
      st.form <= FORM_RESET;
      st.filter <= FILTER_RESET;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.prdata;
  assign pready = st.pready;
  assign pslverr = st.pslverr;
  assign pos_total = st.total;
  assign pos_fwd_step = st.fwd_out;
  assign pos_rev_step = st.rev_out;
  assign position_mode = st.pos_mode;
endmodule

/* verif/ptr_pulse_ref_chk.sv */
// port assertions for the pulse train position reference block
module ptr_pulse_ref_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [31:0] pos_total,
  input wire logic pos_fwd_step,
  input wire logic pos_rev_step,
  input wire logic position_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  sequence s_access;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  a_one_wait: assert property (s_access |=> s_answer)
    else $error("apb answer not one pulse after one wait");
  a_err_ready: assert property (pslverr |-> pready && psel && penable)
    else $error("apb error outside an answer");
  a_fwd_adds: assert property (pos_fwd_step && !pos_rev_step |-> pos_total == $past(pos_total) + 32'h1)
    else $error("forward step did not add one");
  a_rev_subs: assert property (pos_rev_step && !pos_fwd_step |-> pos_total == $past(pos_total) - 32'h1)
    else $error("reverse step did not take one");
  a_total_hold: assert property (!pos_fwd_step && !pos_rev_step && !$past(pready) |-> $stable(pos_total))
    else $error("total moved without a step");
  a_idle_quiet: assert property (!position_mode |-> !pos_fwd_step && !pos_rev_step)
    else $error("step outside position mode");
  a_mode_start: assert property ($fell(reset) |=> position_mode)
    else $error("position mode not on after reset");
  // accepted levels stand at least five cycles, so steps never crowd except in quad x4, where an a edge and a b edge can come a cycle apart
  a_step_gap: assert property (pos_fwd_step |=> (!pos_fwd_step) [*4])
    else $error("forward steps too close");
endmodule
bind ptr_pulse_ref ptr_pulse_ref_chk chk (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr), .pos_total(pos_total), .pos_fwd_step(pos_fwd_step),
  .pos_rev_step(pos_rev_step), .position_mode(position_mode));

/* verif/ptr_host_model.sv */
// host controller model driving the reference pulse lines
module ptr_host_model (
  input wire logic ref_clk,
  output logic ref_in_a,
  output logic ref_in_b
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    ref_in_a = 1'b0;
    ref_in_b = 1'b0;
  end
  task automatic hold(input logic a, input logic b, input int w);
    ref_in_a <= a;
    ref_in_b <= b;
    repeat (w) @(posedge ref_clk);
  endtask
  // 13 cycle levels stay under 4 Mpps; a quadrature cycle of 100 cycles is 1 Mpps
  task automatic send(input logic [2:0] form, input logic fwd, input int n);
    logic neg;
    neg = form > 3'd4;
    for (int i = 0; i < n; i++) begin
      if (form inside {3'd2, 3'd3, 3'd4}) begin
        hold(!fwd, fwd, 25);
        hold(1'b1, 1'b1, 25);
        hold(fwd, !fwd, 25);
        hold(1'b0, 1'b0, 25);
      end else if (form == 3'd0 || form == 3'd5) begin
        hold(neg, fwd ^ neg, 13);
        hold(!neg, fwd ^ neg, 13);
      end else begin
        hold(neg ^ fwd, neg ^ !fwd, 13);
        hold(neg, neg, 13);
      end
    end
  endtask
endmodule

/* verif/testbench.sv */
// self-checking bench for the pulse train position reference block
module testbench import ptr_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, pos_total;
  logic pos_fwd_step, pos_rev_step, position_mode, ref_in_a, ref_in_b;
  logic [41:0] notes[$];
  logic [41:0] e;
  int n_errors, n_tests, cyc;
  ptr_pulse_ref dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_in_a(ref_in_a), .ref_in_b(ref_in_b), .pos_total(pos_total), .pos_fwd_step(pos_fwd_step),
    .pos_rev_step(pos_rev_step), .position_mode(position_mode));
  ptr_host_model host (.ref_clk(ref_clk), .ref_in_a(ref_in_a), .ref_in_b(ref_in_b));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("checks %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic cmp(input logic [7:0] a, input logic [32:0] x, input logic [32:0] y);
    n_tests++;
    if (y !== x) begin
      n_errors++;
      $display("wrong value reg %h expected %h seen %h", a, x, y);
    end
  endtask
  always @(posedge ref_clk) begin
    if (pready === 1'b1) begin
      e = notes.pop_front();
      cmp(e[40:33], e[32:0], {pslverr, e[41] ? prdata : 32'h0});
    end
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_errors++;
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    notes.push_back({!w, a, x});
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {1'b0, d});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask
  task automatic restart(input logic [31:0] c);
    wr(ADDR_CONFIG, c);
    wr(ADDR_CONTROL, 32'h1);
  endtask
  initial begin
    int nf, nr, m, w;
    logic [31:0] cfg;
    logic lv;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    reset = 1'b1;
    nf = $urandom(91);
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    rd(ADDR_CONFIG, CFG_RESET);
    rd(ADDR_ACTIVE, CFG_RESET);
    rd(ADDR_STATUS, 32'h1);
    apb(1'b1, 8'h1c, 32'h5, {1'b1, 32'h0});
    apb(1'b0, 8'h1c, 32'h0, {1'b1, 32'h0});
    $display("test registers done");
    for (int k = 0; k < 3; k++) begin
      w = k == 0 ? 25 : k == 1 ? 100 : 5;
      restart(32'h1 | (32'(k) << 8));
      host.hold(1'b1, 1'b1, w - 2);
      host.hold(1'b0, 1'b1, 2 * w + 9);
      host.hold(1'b1, 1'b1, w + 3);
      host.hold(1'b0, 1'b1, 2 * w + 9);
      rd(ADDR_POSITION, 32'h1);
      $display("test filter %0d done", k);
    end
    for (int f = 0; f < 7; f++) begin
      lv = f > 4;
      host.hold(lv, lv, 60);
      cfg = 32'h201 | (32'(f) << 4);
      restart(cfg);
      nf = 1 + $urandom % 3;
      nr = $urandom % 3;
      m = f == 3 ? 2 : f == 4 ? 4 : 1;
      host.send(3'(f), 1'b1, nf);
      host.send(3'(f), 1'b0, nr);
      host.hold(lv, lv, 40);
      rd(ADDR_ACTIVE, cfg);
      rd(ADDR_FWD_COUNT, 32'(nf * m));
      rd(ADDR_REV_COUNT, 32'(nr * m));
      rd(ADDR_POSITION, 32'((nf - nr) * m));
      cmp(8'hff, {1'b0, 32'((nf - nr) * m)}, {1'b0, pos_total});
      $display("test form %0d done", f);
    end
    restart(32'h271);
    rd(ADDR_ACTIVE, 32'h261);
    rd(ADDR_STATUS, 32'h1f);
    wr(ADDR_STATUS, 32'h4);
    rd(ADDR_STATUS, 32'h1b);
    host.hold(1'b0, 1'b0, 40);
    restart(32'h200);
    host.send(3'h0, 1'b1, 2);
    host.hold(1'b0, 1'b0, 40);
    rd(ADDR_POSITION, 32'h0);
    rd(ADDR_STATUS, 32'h0);
    $display("test method done");
    test_done();
  end
endmodule
